// >>> rtl/tbsr_buffer_ctrl.sv
// control logic of a two-wire bus buffer with stuck-bus recovery
//
// Contract
// R1: enable low keeps inner and outer data and clock lines separated.
// R2: enable low halts or prevents recovery clock pulses and stop generation.
// R3: enable rising after stuck-bus disconnect reconnects at once, no stop needed.
// R4: ready low while disabled, before first connection, or after stuck disconnect.
// R5: ready high only when enabled and the sides are connected.
// R6: outer line low continuously for timeout (30 ms nominal) declares stuck fault.
// R7: traffic passes at 400 kHz with no protocol-level delay added.
// R8: each outer line has its own timer, cleared only when that line is high; the code also clears both timers when enable rises.
// R9: after 40 us wait, up to 16 pulses near 8.5 kHz; stop early on release.
// R10: every recovery attempt ends with a stop on outer clock and data.
// R11: connect only when both sides idle, or one shows stop and other idle.
// R12: lines are sampled input plus pull-down; a low on one side pulls the other.
`timescale 1ns/1ps
`include "tbsr_params.svh"
module tbsr_buffer_ctrl
   import tbsr_pkg::*;
#(
   parameter int TIMEOUT_CYC = `TBSR_TIMEOUT_CYC,
   parameter int RECOV_WAIT_CYC = `TBSR_RECOV_WAIT_CYC,
   parameter int RECOV_HALF_CYC = `TBSR_RECOV_HALF_CYC,
   parameter int RECOV_PULSES = `TBSR_RECOV_PULSES,
   parameter int IDLE_CYC = `TBSR_IDLE_CYC
) (
   // clock and reset (reset stands for the power-on lockout)
   input wire logic clk_sys,
   input wire logic rst_n,
   // control and status
   input wire logic enable,
   output logic ready,
   // inner side data line
   input wire logic innerSideDataLineIn,
   output logic innerSideDataLineOut,
   output logic innerSideDataLineOe,
   // inner side clock line
   input wire logic innerSideClockLineIn,
   output logic innerSideClockLineOut,
   output logic innerSideClockLineOe,
   // outer side data line
   input wire logic outerSideDataLineIn,
   output logic outerSideDataLineOut,
   output logic outerSideDataLineOe,
   // outer side clock line
   input wire logic outerSideClockLineIn,
   output logic outerSideClockLineOut,
   output logic outerSideClockLineOe
);
   ////////////////////////////////////////////////////////////////////////////////
   // input synchronisers and per-side bus watchers
   logic [1:0] enMeta_r;
   logic enPrev_r;
   logic inData, inClock, inStop, inIdle;
   logic outData, outClock, outStop, outIdle;

   tbsr_side_monitor #(.IDLE_CYC(IDLE_CYC)) uInner (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .dataPin(innerSideDataLineIn),
      .clockPin(innerSideClockLineIn),
      .dataSync(inData),
      .clockSync(inClock),
      .stopSeen(inStop),
      .idle(inIdle)
   );

   tbsr_side_monitor #(.IDLE_CYC(IDLE_CYC)) uOuter (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .dataPin(outerSideDataLineIn),
      .clockPin(outerSideClockLineIn),
      .dataSync(outData),
      .clockSync(outClock),
      .stopSeen(outStop),
      .idle(outIdle)
   );

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         enMeta_r <= 2'h0;
         enPrev_r <= 1'h0;
      end else begin
         enMeta_r <= {enMeta_r[0], enable};
         enPrev_r <= enMeta_r[1];
      end
   end

   logic enSync, enRise;
   assign enSync = enMeta_r[1];
   assign enRise = enSync && !enPrev_r;

   ////////////////////////////////////////////////////////////////////////////////
   // per-line stuck-low timers
   logic [`TBSR_CNT_W-1:0] dataTmr_r, clockTmr_r;
   logic dataStuck, clockStuck, stuck;
   logic timerClr;
   tbsr_state_t state_r;
   logic driveClkLow, driveDataLow;

   assign dataStuck = (dataTmr_r == `TBSR_CNT_W'(TIMEOUT_CYC));
   assign clockStuck = (clockTmr_r == `TBSR_CNT_W'(TIMEOUT_CYC));
   assign stuck = dataStuck || clockStuck;
   // an enable rise restarts both stuck-low timers
   assign timerClr = enRise;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dataTmr_r <= '0;
      end else if (outData || timerClr) begin
         dataTmr_r <= '0; // see R8
      end else if (!dataStuck && !driveDataLow) begin
         dataTmr_r <= dataTmr_r + `TBSR_CNT_W'(1); // see R6
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         clockTmr_r <= '0;
      end else if (outClock || timerClr) begin
         clockTmr_r <= '0; // see R8
      end else if (!clockStuck && !driveClkLow) begin
         clockTmr_r <= clockTmr_r + `TBSR_CNT_W'(1); // see R6
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // connection and recovery sequencer
   logic [`TBSR_CNT_W-1:0] seqCnt_r;
   logic [`TBSR_PULSE_W-1:0] pulses_r;
   logic canJoin;

   assign canJoin = (inIdle && outIdle) || (inStop && outIdle) || (outStop && inIdle);
   assign driveClkLow = (state_r == ST_CLK_LOW);
   assign driveDataLow = (state_r == ST_STOP_SETUP);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_STARTUP;
         seqCnt_r <= '0;
         pulses_r <= '0;
      end else begin
         case (state_r)
            ST_STARTUP, ST_DISCONNECTED: begin
               seqCnt_r <= '0;
               pulses_r <= '0;
               if (enRise && state_r == ST_DISCONNECTED) begin
                  state_r <= ST_CONNECTED; // see R3
               end else if (enSync && stuck && state_r == ST_STARTUP) begin
                  // one attempt per fault: a failed recovery stays disconnected
                  state_r <= ST_WAIT; // see R6
               end else if (enSync && canJoin) begin
                  state_r <= ST_CONNECTED; // see R11
               end
            end
            ST_CONNECTED: begin
               seqCnt_r <= '0;
               pulses_r <= '0;
               if (!enSync) begin
                  state_r <= ST_STARTUP; // see R1
               end else if (stuck) begin
                  state_r <= ST_WAIT; // see R6
               end
            end
            ST_WAIT: begin
               seqCnt_r <= seqCnt_r + `TBSR_CNT_W'(1);
               if (seqCnt_r == `TBSR_CNT_W'(RECOV_WAIT_CYC - 1)) begin
                  seqCnt_r <= '0;
                  state_r <= (outData && outClock) ? ST_STOP_SETUP : ST_CLK_LOW; // see R9
               end
            end
            ST_CLK_LOW: begin
               seqCnt_r <= seqCnt_r + `TBSR_CNT_W'(1);
               if (seqCnt_r == `TBSR_CNT_W'(RECOV_HALF_CYC - 1)) begin
                  seqCnt_r <= '0;
                  pulses_r <= pulses_r + `TBSR_PULSE_W'(1);
                  state_r <= ST_CLK_HIGH;
               end
            end
            ST_CLK_HIGH: begin
               seqCnt_r <= seqCnt_r + `TBSR_CNT_W'(1);
               if (seqCnt_r == `TBSR_CNT_W'(RECOV_HALF_CYC - 1)) begin
                  seqCnt_r <= '0;
                  if (outData || pulses_r == `TBSR_PULSE_W'(RECOV_PULSES)) begin
                     state_r <= ST_STOP_SETUP; // see R9
                  end else begin
                     state_r <= ST_CLK_LOW; // see R9
                  end
               end
            end
            ST_STOP_SETUP: begin
               // data held low with clock high, then released: a stop
               seqCnt_r <= seqCnt_r + `TBSR_CNT_W'(1);
               if (seqCnt_r == `TBSR_CNT_W'(RECOV_HALF_CYC - 1)) begin
                  seqCnt_r <= '0;
                  state_r <= ST_STOP_DONE; // see R10
               end
            end
            ST_STOP_DONE: begin
               seqCnt_r <= '0;
               state_r <= ST_DISCONNECTED; // see R10
            end
            default: begin
               state_r <= ST_STARTUP;
            end
         endcase
         // a disable aborts recovery wherever it stands and drops to ST_DISCONNECTED
         if (!enSync && state_r != ST_CONNECTED && state_r != ST_STARTUP) begin
            state_r <= ST_DISCONNECTED; // see R2
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pull-down drive and ready, all registered
   logic joined;
   logic [3:0] oeNow, oeD1_r, oeD2_r, oeEcho;
   assign joined = (state_r == ST_CONNECTED) && enSync;
   assign oeNow = {outerSideClockLineOe, outerSideDataLineOe, innerSideClockLineOe,
      innerSideDataLineOe};
   // our own pull reads back low through the synchronisers for two more cycles
   assign oeEcho = oeNow | oeD1_r | oeD2_r;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         oeD1_r <= '0;
         oeD2_r <= '0;
      end else begin
         oeD1_r <= oeNow;
         oeD2_r <= oeD1_r;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         innerSideDataLineOe <= 1'h0;
         innerSideClockLineOe <= 1'h0;
         outerSideDataLineOe <= 1'h0;
         outerSideClockLineOe <= 1'h0;
         ready <= 1'h0;
      end else begin
         // a low is forwarded only when it is not the echo of our own pull
         innerSideDataLineOe <= joined && !outData && !oeEcho[2]; // see R12
         innerSideClockLineOe <= joined && !outClock && !oeEcho[3]; // see R12
         outerSideDataLineOe <= (joined && !inData && !oeEcho[0]) || driveDataLow; // see R12
         outerSideClockLineOe <= (joined && !inClock && !oeEcho[1]) || driveClkLow; // see R7
         ready <= joined; // see R4, see R5
      end
   end

   assign innerSideDataLineOut = 1'b0;
   assign innerSideClockLineOut = 1'b0;
   assign outerSideDataLineOut = 1'b0;
   assign outerSideClockLineOut = 1'b0;
endmodule : tbsr_buffer_ctrl

// >>> rtl/tbsr_params.svh
// timing constants and counter widths for the two-wire buffer stuck-bus control
`ifndef TBSR_PARAMS_SVH
`define TBSR_PARAMS_SVH

`define TBSR_CLK_HZ 50000000
// stuck-low timeout, nominal 30 ms (window 25..35 ms)
`define TBSR_TIMEOUT_MS 30
`define TBSR_TIMEOUT_CYC ((`TBSR_CLK_HZ / 1000) * `TBSR_TIMEOUT_MS)
// least wait before recovery clocking, 40 us, in whole cycles rounded down
`define TBSR_RECOV_WAIT_US 40
`define TBSR_RECOV_WAIT_CYC ((`TBSR_CLK_HZ / 1000000) * `TBSR_RECOV_WAIT_US)
// recovery clock about 8.5 kHz; half period in cycles
`define TBSR_RECOV_FREQ_HZ 8500
`define TBSR_RECOV_HALF_CYC (`TBSR_CLK_HZ / (2 * `TBSR_RECOV_FREQ_HZ))
`define TBSR_RECOV_PULSES 16
// bus idle time before connection, 95 us typical
`define TBSR_IDLE_US 95
`define TBSR_IDLE_CYC ((`TBSR_CLK_HZ / 1000000) * `TBSR_IDLE_US)
`define TBSR_CNT_W 21
`define TBSR_PULSE_W 5

`endif

// >>> rtl/tbsr_pkg.sv
// types for the two-wire buffer stuck-bus control
package tbsr_pkg;
   typedef enum logic [2:0] {
      ST_STARTUP,
      ST_CONNECTED,
      ST_WAIT,
      ST_CLK_LOW,
      ST_CLK_HIGH,
      ST_STOP_SETUP,
      ST_STOP_DONE,
      ST_DISCONNECTED
   } tbsr_state_t;
endpackage : tbsr_pkg

// >>> rtl/tbsr_side_monitor.sv
// per-side bus watcher: two-flop sync, stop detection and idle timing
`timescale 1ns/1ps
`include "tbsr_params.svh"
module tbsr_side_monitor #(
   parameter int IDLE_CYC = `TBSR_IDLE_CYC
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // raw pins
   input wire logic dataPin,
   input wire logic clockPin,
   // synchronised view
   output logic dataSync,
   output logic clockSync,
   output logic stopSeen,
   output logic idle
);
   logic [1:0] dataMeta_r;
   logic [1:0] clockMeta_r;
   logic dataPrev_r;
   logic [`TBSR_CNT_W-1:0] idleCnt_r;
   logic stopSeen_r;

   assign dataSync = dataMeta_r[1];
   assign clockSync = clockMeta_r[1];
   assign stopSeen = stopSeen_r;
   assign idle = (idleCnt_r == `TBSR_CNT_W'(IDLE_CYC));

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dataMeta_r <= 2'h3;
         clockMeta_r <= 2'h3;
      end else begin
         dataMeta_r <= {dataMeta_r[0], dataPin};
         clockMeta_r <= {clockMeta_r[0], clockPin};
      end
   end

   // stop: data rises while clock is high
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dataPrev_r <= 1'h1;
         stopSeen_r <= 1'h0;
      end else begin
         dataPrev_r <= dataSync;
         stopSeen_r <= dataSync && !dataPrev_r && clockSync;
      end
   end

   // idle: both lines high for the idle time
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         idleCnt_r <= '0;
      end else if (!(dataSync && clockSync)) begin
         idleCnt_r <= '0;
      end else if (idleCnt_r != `TBSR_CNT_W'(IDLE_CYC)) begin
         idleCnt_r <= idleCnt_r + `TBSR_CNT_W'(1);
      end
   end
endmodule : tbsr_side_monitor

// >>> test/tb.sv
// self-checking bench for the two-wire buffer control
`timescale 1ns/1ps
module tb;
   localparam int TO = 2000;
   localparam int WT = 20;
   logic clk_sys, rst_n, enable, ready, frameGo, stuckHold;
   logic [4:0] releaseAfter;
   logic iDataOe, iClkOe, oDataOe, oClkOe, iClkPull, iDataPull, oDataPull;
   logic [3:0] lineOut;
   wire logic iData = !(iDataOe | iDataPull);
   wire logic iClk = !(iClkOe | iClkPull);
   wire logic oData = !(oDataOe | oDataPull);
   wire logic oClk = !oClkOe;
   int num_errors = 0;
   int total_checks = 0;
   int n, gap, pulses;
   tbsr_buffer_ctrl #(.TIMEOUT_CYC(TO), .RECOV_WAIT_CYC(WT), .RECOV_HALF_CYC(30),
      .RECOV_PULSES(16), .IDLE_CYC(50)) i_tbsr_buffer_ctrl (
      .clk_sys(clk_sys), .rst_n(rst_n), .enable(enable), .ready(ready),
      .innerSideDataLineIn(iData), .innerSideDataLineOut(lineOut[0]),
      .innerSideDataLineOe(iDataOe),
      .innerSideClockLineIn(iClk), .innerSideClockLineOut(lineOut[1]),
      .innerSideClockLineOe(iClkOe),
      .outerSideDataLineIn(oData), .outerSideDataLineOut(lineOut[2]),
      .outerSideDataLineOe(oDataOe),
      .outerSideClockLineIn(oClk), .outerSideClockLineOut(lineOut[3]),
      .outerSideClockLineOe(oClkOe));
   tbsr_bus_partner i_tbsr_bus_partner (.frameGo(frameGo), .stuckHold(stuckHold),
      .releaseAfter(releaseAfter), .outerClockWire(oClk), .innerClockPull(iClkPull),
      .innerDataPull(iDataPull), .outerDataPull(oDataPull));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic wait_ready(input logic lvl, input int bound);
      n = 0;
      while (ready !== lvl) begin
         if (n == bound) begin
            num_errors++;
            stop_test();
         end
         n++;
         @(negedge clk_sys);
      end
   endtask : wait_ready
   task automatic count_clk(input int c, output int r);
      logic prev;
      r = 0;
      prev = oClkOe;
      repeat (c) begin
         @(negedge clk_sys);
         r += int'(oClkOe && !prev);
         prev = oClkOe;
      end
   endtask : count_clk
   // gap to first pulse and pulse count, up to the end of the stop drive
   task automatic recover(output int g, output int p);
      logic dPrev, cPrev;
      // the cycle in which ready was seen low already belongs to the gap
      g = 1;
      p = 0;
      dPrev = 1'b0;
      cPrev = 1'b0;
      repeat (3000) begin
         @(negedge clk_sys);
         if (p == 0 && !oClkOe) g++;
         if (oClkOe && !cPrev) p++;
         if (dPrev && !oDataOe) return;
         dPrev = oDataOe;
         cPrev = oClkOe;
      end
      check(16'h0, 16'h1);
   endtask : recover
   ////////////////////////////////////////////////////////////
   task automatic t_startup;
      repeat (20) @(negedge clk_sys);
      check(ready, 1'b0);
      check(16'(lineOut), 16'h0);
      wait_ready(1'b1, 200);
   endtask : t_startup
   task automatic t_forward;
      @(posedge clk_sys) frameGo <= 1'b1;
      count_clk(400, n);
      check(16'(n), 16'hA);
      check(ready, 1'b1);
      @(posedge clk_sys) frameGo <= 1'b0;
   endtask : t_forward
   task automatic t_disable;
      @(posedge clk_sys) enable <= 1'b0;
      repeat (5) @(negedge clk_sys);
      check(ready, 1'b0);
      @(posedge clk_sys) frameGo <= 1'b1;
      count_clk(400, n);
      check(16'(n), 16'h0);
      @(posedge clk_sys) frameGo <= 1'b0;
      enable <= 1'b1;
      wait_ready(1'b1, 200);
   endtask : t_disable
   task automatic t_stuck_early;
      @(posedge clk_sys) stuckHold <= 1'b1;
      releaseAfter <= 5'h3;
      repeat (5) @(negedge clk_sys);
      check(iDataOe, 1'b1);
      wait_ready(1'b0, TO + 50);
      check(n >= TO - 5, 1'b1);
      recover(gap, pulses);
      check(gap >= WT, 1'b1);
      check(16'(pulses), 16'h3);
      @(posedge clk_sys) stuckHold <= 1'b0;
      wait_ready(1'b1, 300);
   endtask : t_stuck_early
   task automatic t_stuck_hard;
      @(posedge clk_sys) stuckHold <= 1'b1;
      releaseAfter <= 5'h0;
      wait_ready(1'b0, TO + 50);
      recover(gap, pulses);
      check(16'(pulses), 16'h10);
      check(ready, 1'b0);
      count_clk(WT + 40, n);
      check(16'(n), 16'h0);
      @(posedge clk_sys) enable <= 1'b0;
      repeat (10) @(posedge clk_sys);
      enable <= 1'b1;
      wait_ready(1'b1, 12);
      wait_ready(1'b0, TO + 50);
      repeat (WT + 40) @(posedge clk_sys);
      enable <= 1'b0;
      count_clk(300, n);
      check(16'(n), 16'h0);
      @(posedge clk_sys) stuckHold <= 1'b0;
      enable <= 1'b1;
      wait_ready(1'b1, 12);
   endtask : t_stuck_hard
   initial begin
      rst_n = 1'b0;
      enable = 1'b1;
      frameGo = 1'b0;
      stuckHold = 1'b0;
      releaseAfter = 5'h0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_startup();
      t_forward();
      t_disable();
      t_stuck_early();
      t_stuck_hard();
      stop_test();
   end
endmodule : tb
bind tbsr_buffer_ctrl tbsr_buffer_ctrl_assertions #(.TIMEOUT_CYC(TIMEOUT_CYC),
   .RECOV_HALF_CYC(RECOV_HALF_CYC), .RECOV_PULSES(RECOV_PULSES)) i_tbsr_buffer_ctrl_assertions (
   .clk_sys, .rst_n, .enable, .ready, .innerSideDataLineIn, .innerSideDataLineOe,
   .innerSideClockLineIn, .innerSideClockLineOe, .outerSideDataLineIn, .outerSideDataLineOe,
   .outerSideClockLineOe);

// >>> test/tbsr_buffer_ctrl_assertions.sv
// port checker for the two-wire buffer control
`timescale 1ns/1ps
module tbsr_buffer_ctrl_assertions #(
   parameter int TIMEOUT_CYC = 2000,
   parameter int RECOV_HALF_CYC = 30,
   parameter int RECOV_PULSES = 16
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // control and status
   input wire logic enable,
   input wire logic ready,
   // bus lines
   input wire logic innerSideDataLineIn,
   input wire logic innerSideDataLineOe,
   input wire logic innerSideClockLineIn,
   input wire logic innerSideClockLineOe,
   input wire logic outerSideDataLineIn,
   input wire logic outerSideDataLineOe,
   input wire logic outerSideClockLineOe
);
   int lowCnt_r, clkRun_r, dataRun_r, pulses_r;
   logic clkOe_r;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////
   // run lengths of the recovery drives and pulses per attempt
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lowCnt_r <= 0;
         clkRun_r <= 0;
         dataRun_r <= 0;
         pulses_r <= 0;
         clkOe_r <= 1'b0;
      end else begin
         lowCnt_r <= (outerSideDataLineIn || !enable) ? 0 : lowCnt_r + 1;
         clkRun_r <= outerSideClockLineOe ? clkRun_r + 1 : 0;
         dataRun_r <= outerSideDataLineOe ? dataRun_r + 1 : 0;
         pulses_r <= ready ? 0 : pulses_r + int'(outerSideClockLineOe && !clkOe_r);
         clkOe_r <= outerSideClockLineOe;
      end
   end
   ////////////////////////////////////////////////////////////
   AST_ISOLATE: assert property ((!enable)[*5] |->
      !innerSideDataLineOe && !innerSideClockLineOe && !outerSideDataLineOe)
      else $error("lines joined while disabled");
   AST_NO_RECOVERY: assert property ((!enable)[*5] |-> !outerSideClockLineOe)
      else $error("recovery clock while disabled");
   AST_READY_OFF: assert property ((!enable)[*5] |-> !ready)
      else $error("ready high while disabled");
   AST_READY_ON: assert property ($rose(ready) |-> enable)
      else $error("ready rose without enable");
   AST_FWD_DATA: assert property (
      (ready && !innerSideDataLineIn && !innerSideDataLineOe)[*4] |-> outerSideDataLineOe)
      else $error("data low not forwarded");
   AST_FWD_CLK: assert property (
      (ready && !innerSideClockLineIn && !innerSideClockLineOe)[*4] |-> outerSideClockLineOe)
      else $error("clock low not forwarded");
   AST_TIMEOUT: assert property (lowCnt_r == TIMEOUT_CYC + 8 |-> !ready)
      else $error("stuck data line not timed out");
   AST_HALF_PERIOD: assert property ($fell(outerSideClockLineOe) && !ready && enable
      |-> clkRun_r == RECOV_HALF_CYC) else $error("recovery half period wrong");
   AST_STOP_PULSE: assert property ($fell(outerSideDataLineOe) && !ready && enable
      |-> dataRun_r == RECOV_HALF_CYC) else $error("stop drive length wrong");
   AST_PULSE_LIMIT: assert property (pulses_r <= RECOV_PULSES)
      else $error("too many recovery pulses");
endmodule : tbsr_buffer_ctrl_assertions

// >>> test/tbsr_bus_partner.sv
// inner-side controller sending a frame and outer-side target stuck on data
`timescale 1ns/1ps
module tbsr_bus_partner (
   // requests from the bench
   input wire logic frameGo,
   input wire logic stuckHold,
   input wire logic [4:0] releaseAfter,
   // resolved outer clock wire
   input wire logic outerClockWire,
   // pull-downs onto the wires
   output logic innerClockPull,
   output logic innerDataPull,
   output logic outerDataPull
);
   int fallCnt = 0;
   initial begin
      innerClockPull = 1'b0;
      innerDataPull = 1'b0;
   end
   // start, nine bits, stop on a free-phase 160 ns link clock
   always @(posedge frameGo) begin
      #7;
      innerDataPull = 1'b1;
      #80;
      for (int b = 0; b < 9; b++) begin
         innerClockPull = 1'b1;
         innerDataPull = b[0];
         #80;
         innerClockPull = 1'b0;
         #80;
      end
      innerClockPull = 1'b1;
      innerDataPull = 1'b1;
      #80;
      innerClockPull = 1'b0;
      #80;
      innerDataPull = 1'b0;
   end
   // target lets go of data after the set count of clock falls (0 = never)
   always @(negedge outerClockWire or negedge stuckHold) begin
      if (!stuckHold) begin
         fallCnt <= 0;
      end else begin
         fallCnt <= fallCnt + 1;
      end
   end
   assign outerDataPull = stuckHold && (releaseAfter == 5'h0 || fallCnt < int'(releaseAfter));
endmodule : tbsr_bus_partner
